// ==== core/fpm_core.sv ====
// converter fault manager: guard arming, shutdown type, group line, restart timing
`timescale 1ns/1ps
// Summary of operation
// (RULE_01) one wired group line joins 1 to 32 converters
// (RULE_02) with in-group propagation on, a local fault pulls the group line low
// (RULE_03) group line held low by another party starts our own shutdown
// (RULE_04) power manager relays low group lines to other selected groups
// (RULE_05) manager may stop upstream bus converter and fire crowbar on errors
// (RULE_06) propagated faults cause regular shutdown; own fault uses its class type
// (RULE_07) propagated error gives fast shutdown; own error also forces low side on
// (RULE_08) regular shutdown honours programmed turn-off delay and falling ramp
// (RULE_09) non-latching protection retries every 130 ms until condition clears
// (RULE_10) restart interval runs from output at zero to next ramp up
// (RULE_11) overvoltage armed above prebias, fast off with low side on
// (RULE_12) overtemperature always armed, regular off with low side off; code arms it only in ramp up and on
// (RULE_13) pretemp and in-window warnings never shut down, only reported
// (RULE_14) tracking guard only during ramp up, disableable, fast off
// (RULE_15) fast shutdown turns both switches off at once, no ramp
// (RULE_16) regular shutdown ramps output down per sequencing settings
// (RULE_17) latching protection stays off until cleared or turn-on recycled
// (RULE_18) group line is open drain, wired-AND
module fpm_core
  import fpm_pkg::*;
#(
  parameter longint unsigned RESTART_CNT = fpm_pkg::RESTART_CYCLES
) (
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  input  wire logic                    clk_en,
  input  wire logic [fpm_pkg::AW-1:0]  reg_addr,
  input  wire logic [fpm_pkg::DW-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [fpm_pkg::DW-1:0]       reg_rdata,
  input  wire logic                    overcurrent_guard,
  input  wire logic                    undervoltage_guard,
  input  wire logic                    overtemp_guard,
  input  wire logic                    tracking_guard,
  input  wire logic                    overvoltage_guard,
  input  wire logic                    pretemp_warning,
  input  wire logic                    output_in_window_warning,
  input  wire logic                    out_above_prebias,
  input  wire logic                    ramp_up_finished,
  input  wire logic                    out_at_zero,
  input  wire logic                    mgr_fast_off,
  input  wire logic                    grp_line_in,
  output logic                         grp_line_out,
  output logic                         grp_line_oe,
  output logic                         ramp_up_req,
  output logic                         ramp_down_req,
  output logic                         fast_off,
  output logic                         low_side_on,
  output logic                         irq
);
  import fpm_pkg::*;

  fpm_state_e     state_q, state_d;
  logic [DW-1:0]  ctrl_q, ctrl_d;
  logic [DW-1:0]  toff_q, toff_d;
  logic [NFC-1:0] fcode_q, fcode_d;
  logic [DW-1:0]  rdata_q, rdata_d;
  logic           own_fault_q, own_fault_d;
  logic           own_err_q, own_err_d;
  logic           latch_q, latch_d;
  logic           cmd_off_q, cmd_off_d;
  logic           pt_q, win_q;
  logic           ramp_up_q, ramp_dn_q, fast_q, lso_q, oe_q;
  logic [NFC-1:0] trip;
  logic [NEV-1:0] events;
  logic [NEV-1:0] irq_st, irq_en;
  logic           active, ext_low, any_trip, cond_clear, turn_on;
  logic           toff_start, toff_done, rst_start, rst_busy, rst_done;
  logic           fclr_wr;

  assign turn_on = ctrl_q[CTRL_TURN_ON];
  assign active  = (state_q == ST_RAMP_UP) || (state_q == ST_ON);
  // our own pull-down is masked so we never shut down on our own drive
  assign ext_low = !grp_line_in && !oe_q; // RULE_03 RULE_18

  // guard arming per protection class
  always_comb begin
    trip        = '0;
    trip[FC_TR] = tracking_guard && (state_q == ST_RAMP_UP) && ctrl_q[CTRL_TRK_EN_BIT]; // RULE_14
    trip[FC_OT] = overtemp_guard && active; // RULE_12
    trip[FC_OC] = overcurrent_guard && active && out_above_prebias;
    trip[FC_UV] = undervoltage_guard && (state_q == ST_ON);
    trip[FC_OV] = overvoltage_guard && active && out_above_prebias; // RULE_11
  end
  assign any_trip   = |trip;
  // only overtemperature and a held group line can be judged while off
  assign cond_clear = !overtemp_guard && !ext_low;
  assign fclr_wr    = reg_wr && (reg_addr == OFF_FCLR);

  // shutdown and restart sequencing
  always_comb begin
    state_d     = state_q;
    own_fault_d = own_fault_q;
    own_err_d   = own_err_q;
    latch_d     = latch_q;
    cmd_off_d   = cmd_off_q;
    toff_start  = 1'b0;
    rst_start   = 1'b0;
    events      = '0;
    // set wins over the software clear
    fcode_d = (fclr_wr ? (fcode_q & ~reg_wdata[NFC-1:0]) : fcode_q) | trip;
    case (state_q)
      ST_OFF: begin
        if (turn_on) begin
          state_d   = ST_RAMP_UP;
          cmd_off_d = 1'b0;
        end
      end
      ST_RAMP_UP, ST_ON: begin
        if (any_trip) begin
          events[EV_FAULT] = 1'b1;
          own_fault_d      = 1'b1;
          own_err_d        = trip[FC_OV]; // RULE_07 RULE_11
          latch_d          = |(trip & ctrl_q[CTRL_LATCH_LSB +: NFC]); // RULE_17
          if (trip[FC_OV] || trip[FC_OC] || trip[FC_TR]) begin
            state_d = ST_FAST_OFF; // RULE_06 RULE_14
          end else begin
            state_d    = ST_TOFF_DLY; // RULE_06 RULE_12
            toff_start = 1'b1;
          end
        end else if (ext_low) begin
          events[EV_GROUP] = 1'b1;
          own_err_d        = 1'b0;
          latch_d          = 1'b0;
          if (mgr_fast_off) begin
            state_d = ST_FAST_OFF; // RULE_07
          end else begin
            state_d    = ST_TOFF_DLY; // RULE_06
            toff_start = 1'b1;
          end
        end else if (!turn_on) begin
          cmd_off_d  = 1'b1;
          state_d    = ST_TOFF_DLY;
          toff_start = 1'b1;
        end else if ((state_q == ST_RAMP_UP) && ramp_up_finished) begin
          state_d = ST_ON; // RULE_13
        end
      end
      ST_TOFF_DLY: begin
        if (toff_done) begin
          state_d = ST_RAMP_DN; // RULE_08
        end
      end
      ST_RAMP_DN, ST_FAST_OFF: begin
        if (out_at_zero) begin
          if (cmd_off_q) begin
            state_d = ST_OFF;
          end else begin
            state_d   = ST_HICCUP; // RULE_10
            rst_start = 1'b1;
          end
        end
      end
      ST_HICCUP: begin
        if (rst_done) begin
          if (latch_q) begin
            state_d = ST_LATCHED; // RULE_17
          end else if (cond_clear && turn_on) begin
            state_d          = ST_RAMP_UP; // RULE_09
            own_fault_d      = 1'b0;
            own_err_d        = 1'b0;
            events[EV_RESTART] = 1'b1;
          end else if (!turn_on) begin
            state_d     = ST_OFF;
            own_fault_d = 1'b0;
          end else begin
            rst_start = 1'b1; // RULE_09
          end
        end
      end
      ST_LATCHED: begin
        // turn-on recycle passes through off; cleared codes restart directly
        if (!turn_on) begin
          state_d     = ST_OFF; // RULE_17
          own_fault_d = 1'b0;
          latch_d     = 1'b0;
        end else if ((fcode_q == '0) && cond_clear) begin
          state_d          = ST_RAMP_UP; // RULE_17
          own_fault_d      = 1'b0;
          latch_d          = 1'b0;
          events[EV_RESTART] = 1'b1;
        end
      end
      default: state_d = ST_OFF;
    endcase
    // warnings only raise an event, never a shutdown
    events[EV_WARN] = (pretemp_warning && !pt_q) || (!output_in_window_warning && win_q); // RULE_13
  end

  // register writes and read mux; read data valid in the cycle after the strobe
  always_comb begin
    ctrl_d  = ctrl_q;
    toff_d  = toff_q;
    rdata_d = '0;
    if (reg_wr) begin
      if (reg_addr == OFF_CTRL) begin
        ctrl_d = {{(DW-CTRL_LATCH_LSB-NFC){1'b0}}, reg_wdata[CTRL_LATCH_LSB+NFC-1:0]};
      end else if (reg_addr == OFF_TOFF) begin
        toff_d = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_addr == OFF_CTRL) begin
        rdata_d = ctrl_q;
      end else if (reg_addr == OFF_STAT) begin
        rdata_d = {8'h00, ext_low, oe_q, output_in_window_warning, pretemp_warning,
                   latch_q, state_q}; // RULE_13
      end else if (reg_addr == OFF_FCODE) begin
        rdata_d = {{(DW-NFC){1'b0}}, fcode_q};
      end else if (reg_addr == OFF_TOFF) begin
        rdata_d = toff_q;
      end else if (reg_addr == OFF_IRQ_ST) begin
        rdata_d = {{(DW-NEV){1'b0}}, irq_st};
      end else if (reg_addr == OFF_IRQ_EN) begin
        rdata_d = {{(DW-NEV){1'b0}}, irq_en};
      end
    end
  end

  // all state, including registered drive outputs computed from the next state
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q     <= ST_OFF;
      ctrl_q      <= CTRL_RST;
      toff_q      <= TOFF_RST;
      fcode_q     <= '0;
      rdata_q     <= '0;
      own_fault_q <= 1'b0;
      own_err_q   <= 1'b0;
      latch_q     <= 1'b0;
      cmd_off_q   <= 1'b0;
      pt_q        <= 1'b0;
      win_q       <= 1'b0;
      ramp_up_q   <= 1'b0;
      ramp_dn_q   <= 1'b0;
      fast_q      <= 1'b0;
      lso_q       <= 1'b0;
      oe_q        <= 1'b0;
    end else if (clk_en) begin
      state_q     <= state_d;
      ctrl_q      <= ctrl_d;
      toff_q      <= toff_d;
      fcode_q     <= fcode_d;
      rdata_q     <= rdata_d;
      own_fault_q <= own_fault_d;
      own_err_q   <= own_err_d;
      latch_q     <= latch_d;
      cmd_off_q   <= cmd_off_d;
      pt_q        <= pretemp_warning;
      win_q       <= output_in_window_warning;
      ramp_up_q   <= (state_d == ST_RAMP_UP);
      ramp_dn_q   <= (state_d == ST_RAMP_DN); // RULE_16
      fast_q      <= (state_d == ST_FAST_OFF); // RULE_15
      lso_q       <= (state_d == ST_FAST_OFF) && own_err_d; // RULE_07 RULE_11
      oe_q        <= own_fault_d && ctrl_d[CTRL_PROP_BIT]; // RULE_02
    end
  end

  assign reg_rdata     = rdata_q;
  assign grp_line_out  = 1'b0; // RULE_18
  assign grp_line_oe   = oe_q; // RULE_01
  assign ramp_up_req   = ramp_up_q;
  assign ramp_down_req = ramp_dn_q;
  assign fast_off      = fast_q;
  assign low_side_on   = lso_q;

  // programmed turn-off delay, in clock cycles
  fpm_interval_timer #(.W(DW)) u_toff_tmr (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .start    (toff_start),
    .load_val (toff_q),
    .busy     (),
    .done     (toff_done)
  );

  // restart interval counts only from output at zero, so delay setting adds nothing
  fpm_interval_timer #(.W(TMR_W)) u_rst_tmr (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .start    (rst_start),
    .load_val (RESTART_CNT[TMR_W-1:0]),
    .busy     (rst_busy),
    .done     (rst_done)
  );

  fpm_irq_flags #(.N(NEV)) u_irq (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .events  (events),
    .en_wr   (reg_wr && (reg_addr == OFF_IRQ_EN)),
    .clr_wr  (reg_wr && (reg_addr == OFF_IRQ_CLR)),
    .wdata   (reg_wdata[NEV-1:0]),
    .status  (irq_st),
    .enable  (irq_en),
    .irq     (irq)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_reach_zero;
    clk_en && (state_q inside {ST_RAMP_DN, ST_FAST_OFF}) && out_at_zero && !cmd_off_q;
  endsequence

  grp_pull_low_a: assert property (clk_en && active && any_trip && ctrl_q[CTRL_PROP_BIT]
    |=> grp_line_oe) else $error("group line not pulled on fault"); // RULE_02
  peer_shutdown_a: assert property (clk_en && active && !any_trip && ext_low
    |=> state_q inside {ST_TOFF_DLY, ST_FAST_OFF}) else $error("no shutdown on low line"); // RULE_03
  err_fast_lso_a: assert property (clk_en && active && trip[FC_OV]
    |=> fast_off && low_side_on) else $error("overvoltage not fast with low side"); // RULE_07
  ot_regular_a: assert property (clk_en && active && (trip == 5'h02)
    |=> (state_q == ST_TOFF_DLY) && !low_side_on && !fast_off) else $error("ot off wrong"); // RULE_12
  warn_no_off_a: assert property (clk_en && (state_q == ST_ON) && !any_trip && !ext_low && turn_on
    |=> state_q == ST_ON) else $error("warning caused shutdown"); // RULE_13
  trk_ramp_only_a: assert property (clk_en && (state_q == ST_RAMP_UP) && tracking_guard // RULE_14
    && ctrl_q[CTRL_TRK_EN_BIT] && !overvoltage_guard |=> fast_off && !low_side_on)
    else $error("tracking trip not fast with low side off");
  fast_no_ramp_a: assert property (clk_en && active && (trip[FC_OC] || trip[FC_TR]) // RULE_15
    |=> fast_off && !ramp_down_req && !ramp_up_req) else $error("fast off while ramping");
  toff_hold_a: assert property (clk_en && (state_q == ST_TOFF_DLY) && !toff_done
    |=> state_q == ST_TOFF_DLY) else $error("turn-off delay cut short"); // RULE_08
  hiccup_start_a: assert property (s_reach_zero |=> (state_q == ST_HICCUP) && rst_busy)
    else $error("restart timer not started at zero"); // RULE_10
  restart_wait_a: assert property (clk_en && (state_q == ST_HICCUP) && (state_d == ST_RAMP_UP)
    |-> rst_done) else $error("restart before interval"); // RULE_09
endmodule

// ==== core/fpm_interval_timer.sv ====
// loadable down-counter with busy level and one-cycle done pulse
`timescale 1ns/1ps
module fpm_interval_timer #(
  parameter int W = 24
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  input  wire logic         start,
  input  wire logic [W-1:0] load_val,
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         busy_q;
  logic         busy_d;
  logic         done_q;
  logic         done_d;

  // a zero load still takes one cycle so done never coincides with start
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d  = load_val;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q & clk_en;
endmodule

// ==== core/fpm_irq_flags.sv ====
// sticky event flags with enable mask, write-one-to-clear and level interrupt
`timescale 1ns/1ps
module fpm_irq_flags #(
  parameter int N = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  input  wire logic [N-1:0] events,
  input  wire logic         en_wr,
  input  wire logic         clr_wr,
  input  wire logic [N-1:0] wdata,
  output logic [N-1:0]      status,
  output logic [N-1:0]      enable,
  output logic              irq
);
  logic [N-1:0] st_q;
  logic [N-1:0] st_d;
  logic [N-1:0] en_q;
  logic [N-1:0] en_d;

  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    st_d = (clr_wr ? (st_q & ~wdata) : st_q) | events;
    en_d = en_wr ? wdata : en_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q <= '0;
      en_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
      en_q <= en_d;
    end
  end

  assign status = st_q;
  assign enable = en_q;
  assign irq    = |(st_q & en_q);
endmodule

// ==== include/fpm_pkg.sv ====
// constants, register map and state encoding of the fault propagation manager
package fpm_pkg;
  localparam int DW = 16;
  localparam int AW = 8;

  // register byte offsets
  localparam logic [AW-1:0] OFF_CTRL    = 8'h00;
  localparam logic [AW-1:0] OFF_STAT    = 8'h04;
  localparam logic [AW-1:0] OFF_FCODE   = 8'h08;
  localparam logic [AW-1:0] OFF_FCLR    = 8'h0c;
  localparam logic [AW-1:0] OFF_TOFF    = 8'h10;
  localparam logic [AW-1:0] OFF_IRQ_ST  = 8'h14;
  localparam logic [AW-1:0] OFF_IRQ_EN  = 8'h18;
  localparam logic [AW-1:0] OFF_IRQ_CLR = 8'h1c;

  // control register fields
  localparam int CTRL_PROP_BIT   = 0;
  localparam int CTRL_TRK_EN_BIT = 1;
  localparam int CTRL_TURN_ON    = 2;
  localparam int CTRL_LATCH_LSB  = 3;
  localparam logic [DW-1:0] CTRL_RST = 16'h0002;
  localparam logic [DW-1:0] TOFF_RST = 16'h0000;

  // fault code bit positions, shared by latch field and fault code register
  localparam int FC_TR = 0;
  localparam int FC_OT = 1;
  localparam int FC_OC = 2;
  localparam int FC_UV = 3;
  localparam int FC_OV = 4;
  localparam int NFC   = 5;

  // interrupt events
  localparam int EV_FAULT   = 0;
  localparam int EV_GROUP   = 1;
  localparam int EV_RESTART = 2;
  localparam int EV_WARN    = 3;
  localparam int NEV        = 4;

  // group size limits on one wired line
  localparam int GROUP_MIN = 1;
  localparam int GROUP_MAX = 32;

  // restart interval
  localparam longint unsigned CLK_HZ         = 40000000;
  localparam longint unsigned RESTART_MS     = 130;
  localparam longint unsigned RESTART_CYCLES = (RESTART_MS * CLK_HZ) / 1000;
  localparam int              TMR_W          = 24;

  typedef enum logic [2:0] {
    ST_OFF      = 3'b000,
    ST_RAMP_UP  = 3'b001,
    ST_ON       = 3'b010,
    ST_TOFF_DLY = 3'b011,
    ST_RAMP_DN  = 3'b100,
    ST_FAST_OFF = 3'b101,
    ST_HICCUP   = 3'b110,
    ST_LATCHED  = 3'b111
  } fpm_state_e;
endpackage

// ==== verification/fault_propagation_manager_tb_top.sv ====
// self-checking bench: register access and protection scenarios of fpm_core
`timescale 1ns/1ps
module fault_propagation_manager_tb_top;
  import fpm_pkg::*;
  localparam int         RC     = 20;
  localparam logic [4:0] FAST_M = 5'h15; // classes that turn off fast
  localparam logic [4:0] LSW_M  = 5'h10; // only overvoltage keeps low side on
  logic          sys_clk, resetn, reg_wr, reg_rd, clk_en;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata;
  logic [4:0]    guard;
  logic          pretemp, in_window, peer_pull, peer_error, irq;
  logic          ramp_up_finished, out_at_zero, out_above_prebias, grp_line_in, mgr_fast_off;
  logic          grp_line_out, grp_line_oe, ramp_up_req, ramp_down_req, fast_off, low_side_on;
  int            errors, checked, n;

  // clock
  always #12.5 sys_clk = ~sys_clk;

  fpm_core #(.RESTART_CNT(RC)) fpm_core_inst (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .overcurrent_guard(guard[FC_OC]), .undervoltage_guard(guard[FC_UV]),
    .overtemp_guard(guard[FC_OT]), .tracking_guard(guard[FC_TR]),
    .overvoltage_guard(guard[FC_OV]), .pretemp_warning(pretemp),
    .output_in_window_warning(in_window), .out_above_prebias(out_above_prebias),
    .ramp_up_finished(ramp_up_finished), .out_at_zero(out_at_zero),
    .mgr_fast_off(mgr_fast_off), .grp_line_in(grp_line_in), .grp_line_out(grp_line_out),
    .grp_line_oe(grp_line_oe), .ramp_up_req(ramp_up_req), .ramp_down_req(ramp_down_req),
    .fast_off(fast_off), .low_side_on(low_side_on), .irq(irq));

  fpm_far_side fpm_far_side_inst (
    .sys_clk(sys_clk), .resetn(resetn), .ramp_up_req(ramp_up_req),
    .ramp_down_req(ramp_down_req), .fast_off(fast_off), .grp_line_oe(grp_line_oe),
    .grp_line_out(grp_line_out), .peer_pull(peer_pull), .peer_error(peer_error),
    .ramp_up_finished(ramp_up_finished), .out_at_zero(out_at_zero),
    .out_above_prebias(out_above_prebias), .grp_line_in(grp_line_in),
    .mgr_fast_off(mgr_fast_off));

  task complete_run;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read one word and compare the masked value; data stand one cycle only
  task rd(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, exp);
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: pick = ramp_up_req;
      1: pick = ramp_down_req;
      2: pick = out_at_zero;
      3: pick = fast_off;
      default: pick = ramp_up_finished;
    endcase
  endfunction

  // bounded wait; n returns the cycles spent
  task wait_for(input int k, input int lim);
    n = 0;
    #1;
    while (pick(k) !== 1'b1) begin
      if (n >= lim) begin
        errors++;
        $display("[ERR] %0t wait %0d timed out", $time, k);
        complete_run;
      end
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  task go_on;
    wait_for(4, 60);
    repeat (3) @(posedge sys_clk);
    rd(OFF_STAT, 16'h0007, 16'h0002);
  endtask

  // raise one guard for three cycles and look at the first reaction
  task trip(input int k, input logic oe_exp);
    @(posedge sys_clk);
    guard[k] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(16'(fast_off), 16'(FAST_M[k]));
    chk(16'(low_side_on), 16'(LSW_M[k]));
    chk(16'(grp_line_oe), 16'(oe_exp));
    @(posedge sys_clk);
    guard[k] <= 1'b0;
  endtask

  // main sequence
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    guard = 5'h00;
    pretemp = 1'b0;
    in_window = 1'b1;
    peer_pull = 1'b0;
    peer_error = 1'b0;
    errors = 0;
    checked = 0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(OFF_CTRL, 16'hffff, CTRL_RST);
    rd(OFF_TOFF, 16'hffff, TOFF_RST);
    rd(OFF_STAT, 16'hffff, 16'h0020);
    rd(8'h20, 16'hffff, 16'h0000);
    wr(OFF_CTRL, 16'h0007);
    go_on;
    // warnings only report; first masked, then enabled and cleared
    @(posedge sys_clk);
    pretemp <= 1'b1;
    in_window <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(16'(irq), 16'h0000);
    rd(OFF_STAT, 16'h0037, 16'h0012);
    rd(OFF_IRQ_ST, 16'h000f, 16'h0008);
    wr(OFF_IRQ_EN, 16'h0008);
    #1;
    chk(16'(irq), 16'h0001);
    pretemp <= 1'b0;
    in_window <= 1'b1;
    wr(OFF_IRQ_CLR, 16'h0008);
    #1;
    chk(16'(irq), 16'h0000);
    // each class but tracking from steady state, turn-off delay varied per class
    for (int k = FC_OT; k <= FC_OV; k++) begin
      wr(OFF_TOFF, 16'(3 * k));
      trip(k, 1'b1);
      if (!FAST_M[k]) begin
        wait_for(1, 3 * k + 6);
        chk(16'(n + 3 >= 3 * k), 16'h0001);
      end
      rd(OFF_FCODE, 16'h001f, 16'(1 << k));
      wait_for(2, 60);
      wait_for(0, RC + 10);
      chk(16'(n >= RC && n <= RC + 4), 16'h0001);
      wr(OFF_FCLR, 16'h001f);
      go_on;
    end
    // peer pulls the line: fault gives regular, error gives fast shutdown
    for (int e = 0; e < 2; e++) begin
      @(posedge sys_clk);
      peer_error <= e[0];
      peer_pull <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(16'(fast_off), 16'(e[0]));
      chk(16'(low_side_on), 16'h0000);
      chk(16'(grp_line_oe), 16'h0000);
      chk(16'(grp_line_out), 16'h0000);
      if (e == 0) begin
        wait_for(1, 30);
      end
      @(posedge sys_clk);
      peer_pull <= 1'b0;
      peer_error <= 1'b0;
      wait_for(0, RC + 60);
      go_on;
    end
    // latching undervoltage with in-group propagation off
    wr(OFF_CTRL, 16'h0046);
    trip(FC_UV, 1'b0);
    wait_for(2, 60);
    repeat (RC + 8) @(posedge sys_clk);
    #1;
    chk(16'(ramp_up_req), 16'h0000);
    rd(OFF_STAT, 16'h0007, 16'h0007);
    wr(OFF_FCLR, 16'h001f);
    wait_for(0, 10);
    go_on;
    // tracking guard ignored while disabled, trips fast during ramp up
    wr(OFF_CTRL, 16'h0001);
    wait_for(2, 60);
    guard[FC_TR] <= 1'b1;
    wr(OFF_CTRL, 16'h0005);
    go_on;
    wr(OFF_CTRL, 16'h0001);
    wait_for(2, 60);
    wr(OFF_CTRL, 16'h0007);
    wait_for(3, 20);
    chk(16'(low_side_on), 16'h0000);
    guard[FC_TR] <= 1'b0;
    rd(OFF_FCODE, 16'h001f, 16'h0001);
    rd(OFF_IRQ_ST, 16'h0007, 16'h0007);
    wr(OFF_IRQ_EN, 16'h0007);
    #1;
    chk(16'(irq), 16'h0001);
    wr(OFF_IRQ_CLR, 16'h0007);
    #1;
    chk(16'(irq), 16'h0000);
    // clock enable low drops a write strobe and freezes all state
    clk_en <= 1'b0;
    wr(OFF_TOFF, 16'h0005);
    clk_en <= 1'b1;
    rd(OFF_TOFF, 16'hffff, 16'h000c);
    complete_run;
  end
endmodule

// ==== verification/fpm_far_side.sv ====
// far side model: output stage, one peer converter and the power manager relay
`timescale 1ns/1ps
module fpm_far_side #(
  parameter int LVL_MAX = 8
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic ramp_up_req,
  input  wire logic ramp_down_req,
  input  wire logic fast_off,
  input  wire logic grp_line_oe,
  input  wire logic grp_line_out,
  input  wire logic peer_pull,
  input  wire logic peer_error,
  output logic      ramp_up_finished,
  output logic      out_at_zero,
  output logic      out_above_prebias,
  output logic      grp_line_in,
  output logic      mgr_fast_off
);
  logic [3:0] lvl_q;
  logic [3:0] lvl_d;
  logic       line;

  // wired-AND line with pull-up: our drive or the peer's pull takes it low
  assign line = (grp_line_oe ? grp_line_out : 1'b1) & ~peer_pull;
  assign grp_line_in = line;
  // manager relays a low line, marked as an error when the peer reports one
  assign mgr_fast_off = peer_error & ~line;
  // output level: fast off discharges in big steps so the pulse is seen
  always_comb begin
    lvl_d = lvl_q;
    if (fast_off) begin
      lvl_d = (lvl_q > 4'h2) ? lvl_q - 4'h2 : 4'h0;
    end else if (ramp_down_req && lvl_q != 4'h0) begin
      lvl_d = lvl_q - 4'h1;
    end else if (ramp_up_req && lvl_q != 4'(LVL_MAX)) begin
      lvl_d = lvl_q + 4'h1;
    end
  end
  // level register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      lvl_q <= 4'h0;
    end else begin
      lvl_q <= lvl_d;
    end
  end
  // status seen by the converter; prebias sits one step above zero
  assign ramp_up_finished  = (lvl_q == 4'(LVL_MAX));
  assign out_at_zero       = (lvl_q == 4'h0);
  assign out_above_prebias = (lvl_q > 4'h1);
endmodule
